// >>> logic/asram_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// - read is strobe high, select low, gate low; memory drives data
// - write happens during select-low and strobe-low overlap
// - write data stable 25 ns before write end, held 0 ns after
// - address valid by write start, 35 ns before end, held after
// - strobe low at least 35 ns; select low 35 ns before end
// - successive write cycles at least 45 ns apart
// - successive read cycles at least 45 ns apart
// - address valid no later than select falling for a read
// - select held high from before the low-voltage period
// - after retention wait one read cycle before any access
module asram_ctrl
   import asram_pkg::*;
#(
   parameter int ADDR_W = ASRAM_ADDR_W,
   parameter int DATA_W = ASRAM_DATA_W
) (
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   input  wire logic              req_valid,
   output      logic              req_ready,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output      logic              rsp_valid,
   output      logic [DATA_W-1:0] rsp_rdata,
   input  wire logic              retain_req,
   output      logic              retain_ack,
   output      logic [ADDR_W-1:0] word_address,
   output      logic              select_n,
   output      logic              gate_n,
   output      logic              strobe_n,
   input  wire logic [DATA_W-1:0] byte_bus_in,
   output      logic [DATA_W-1:0] byte_bus_out,
   output      logic              byte_bus_oe_n
);
   localparam logic [3:0] N_STROBE = 4'(CYC_STROBE);
   localparam logic [3:0] N_WREC = 4'(CYC_CYCLE - CYC_STROBE);
   // bus reaches rsp through two flops, so hold the gate one edge longer
   localparam logic [3:0] N_ACCESS = 4'(CYC_ACCESS + 1);
   localparam logic [3:0] N_RREC = 4'(CYC_RELEASE);
   localparam logic [3:0] N_WAKE = 4'(CYC_CYCLE);

   asram_state_t state;
   asram_state_t next_state;
   logic [DATA_W-1:0] bus_s1;
   logic [DATA_W-1:0] bus_s2;
   logic [3:0] next_count;
   logic next_load;

   asram_timer_if tif();

   asram_timer u_timer (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .tif     (tif)
   );

   // pins from the memory are asynchronous to ref_clk
   for (genvar b = 0; b < DATA_W; b++) begin : g_bus_sync
      always_ff @(posedge ref_clk or negedge resetn) begin
         if (!resetn) begin
            bus_s1[b] <= 1'b0;
         end else begin
            bus_s1[b] <= byte_bus_in[b];
         end
      end

      always_ff @(posedge ref_clk or negedge resetn) begin
         if (!resetn) begin
            bus_s2[b] <= 1'b0;
         end else begin
            bus_s2[b] <= bus_s1[b];
         end
      end
   end

   assign req_ready = (state == ASRAM_IDLE) && !retain_req;
   assign tif.load = next_load;
   assign tif.count = next_count;

   always_comb begin
      next_state = state;
      next_load = 1'b0;
      next_count = 4'h0;
      case (state)
         ASRAM_IDLE: begin
            if (retain_req) begin
               next_state = ASRAM_RETAIN;
            end else if (req_valid && req_write) begin
               next_state = ASRAM_WRITE;
               next_load = 1'b1;
               next_count = N_STROBE;
            end else if (req_valid) begin
               next_state = ASRAM_READ;
               next_load = 1'b1;
               next_count = N_ACCESS;
            end
         end
         ASRAM_WRITE: begin
            if (tif.done) begin
               next_state = ASRAM_WREC;
               next_load = 1'b1;
               next_count = N_WREC;
            end
         end
         ASRAM_WREC: begin
            if (tif.done) begin
               next_state = ASRAM_IDLE;
            end
         end
         ASRAM_READ: begin
            if (tif.done) begin
               next_state = ASRAM_RREC;
               next_load = 1'b1;
               next_count = N_RREC;
            end
         end
         ASRAM_RREC: begin
            if (tif.done) begin
               next_state = ASRAM_IDLE;
            end
         end
         ASRAM_RETAIN: begin
            if (!retain_req) begin
               next_state = ASRAM_WAKE;
               next_load = 1'b1;
               next_count = N_WAKE;
            end
         end
         ASRAM_WAKE: begin
            if (tif.done) begin
               next_state = ASRAM_IDLE;
            end
         end
         default: begin
            next_state = ASRAM_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= ASRAM_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // address moves on the edge that drops select; zero setup is allowed
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         word_address <= '0;
      end else if (state == ASRAM_IDLE && req_valid && req_ready) begin
         word_address <= req_addr;
      end
   end

   // write data leads the write end by the whole strobe width
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         byte_bus_out <= '0;
      end else if (state == ASRAM_IDLE && req_valid && req_ready) begin
         byte_bus_out <= req_wdata;
      end
   end

   // address and data held through recovery, so 0 ns hold is met
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         select_n <= 1'b1;
      end else begin
         select_n <= !(next_state == ASRAM_WRITE ||
                       next_state == ASRAM_READ);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         strobe_n <= 1'b1;
      end else begin
         strobe_n <= !(next_state == ASRAM_WRITE);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         gate_n <= 1'b1;
      end else begin
         gate_n <= !(next_state == ASRAM_READ);
      end
   end

   // drive only in write and write recovery; gate is high then
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         byte_bus_oe_n <= 1'b1;
      end else begin
         byte_bus_oe_n <= !(next_state == ASRAM_WRITE ||
                            next_state == ASRAM_WREC);
      end
   end

   // bus_s2 shows the pins of two edges back, still inside the gate window
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= (state == ASRAM_READ) && tif.done;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rsp_rdata <= '0;
      end else if ((state == ASRAM_READ) && tif.done) begin
         rsp_rdata <= bus_s2;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         retain_ack <= 1'b0;
      end else begin
         retain_ack <= (next_state == ASRAM_RETAIN);
      end
   end
endmodule

// >>> logic/asram_pkg.sv
package asram_pkg;
   localparam int ASRAM_ADDR_W = 19;
   localparam int ASRAM_DATA_W = 8;
   localparam int ASRAM_DEPTH = 524288;
   localparam int ASRAM_CLK_PS = 25000;
   // pin timing, picoseconds
   localparam int T_CYCLE_PS = 45000;
   localparam int T_STROBE_W_PS = 35000;
   localparam int T_DATA_SETUP_PS = 25000;
   localparam int T_ADDR_SETUP_PS = 35000;
   localparam int T_GATE_TO_DATA_PS = 20000;
   localparam int T_ADDR_TO_DATA_PS = 45000;
   localparam int T_RELEASE_PS = 15000;
   // least times round up
   localparam int CYC_CYCLE =
      (T_CYCLE_PS + ASRAM_CLK_PS - 1) / ASRAM_CLK_PS;
   localparam int CYC_STROBE =
      (T_STROBE_W_PS + ASRAM_CLK_PS - 1) / ASRAM_CLK_PS;
   localparam int CYC_ACCESS =
      (T_ADDR_TO_DATA_PS + ASRAM_CLK_PS - 1) / ASRAM_CLK_PS;
   localparam int CYC_RELEASE =
      (T_RELEASE_PS + ASRAM_CLK_PS - 1) / ASRAM_CLK_PS;
   localparam logic [3:0] TIMER_RESET = 4'h0;
   typedef enum logic [2:0] {
      ASRAM_IDLE, ASRAM_WRITE, ASRAM_WREC, ASRAM_READ, ASRAM_RREC,
      ASRAM_RETAIN, ASRAM_WAKE
   } asram_state_t;
endpackage

// >>> logic/asram_timer_if.sv
`timescale 1ns/100ps
interface asram_timer_if;
   logic       load;
   logic [3:0] count;
   logic       done;
   modport owner (output load, output count, input done);
   modport timer (input load, input count, output done);
endinterface

// >>> logic/asram_timer.sv
`timescale 1ns/100ps
module asram_timer
   import asram_pkg::*;
(
   input wire logic    ref_clk,
   input wire logic    resetn,
   asram_timer_if.timer tif
);
   logic [3:0] left;

   // loading n makes done rise n cycles later
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         left <= TIMER_RESET;
      end else if (tif.load) begin
         left <= tif.count;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end

   // no path back from load, which the owner decodes from done
   assign tif.done = (left == 4'h0);
endmodule

// >>> verification/asram_mem_model.sv
`timescale 1ns/100ps
module asram_mem_model
   import asram_pkg::*;
#(
   parameter real ACC_NS  = 20.0,
   parameter real ADDR_NS = 45.0
) (
   input  wire logic                    select_n,
   input  wire logic                    gate_n,
   input  wire logic                    strobe_n,
   input  wire logic [ASRAM_ADDR_W-1:0] word_address,
   input  wire logic [ASRAM_DATA_W-1:0] host_data,
   input  wire logic                    host_oe_n,
   output wire logic [ASRAM_DATA_W-1:0] byte_bus
);
   logic [7:0] mem [bit [ASRAM_ADDR_W-1:0]];
   logic       drive;
   logic       wr;
   logic       armed = 1'b0;
   logic [7:0] rd;
   logic [ASRAM_ADDR_W-1:0] addr_seen;
   assign wr = !select_n && !strobe_n;
   // data is invalid until the address has stood for the access time
   assign #(ADDR_NS) addr_seen = word_address;
   assign #(ACC_NS) drive = !select_n && !gate_n && strobe_n;
   always @(word_address)
      rd = mem.exists(word_address) ? mem[word_address] : 8'hA5;
   // floating bus shows the inverse so stale data never passes
   assign byte_bus = !host_oe_n ? host_data :
                     (drive && addr_seen === word_address) ? rd : ~rd;
   // write lands as select or strobe rises; x to 0 at start is no write
   always @(posedge wr) armed = 1'b1;
   always @(negedge wr) begin
      if (armed) begin
         mem[word_address] = host_data;
         rd = host_data;
      end
   end
endmodule

// >>> verification/asram_ctrl_asserts.sv
`timescale 1ns/100ps
module asram_ctrl_asserts #(
   parameter int ADDR_W = 19,
   parameter int DATA_W = 8
) (
   input wire logic              ref_clk,
   input wire logic              resetn,
   input wire logic              retain_ack,
   input wire logic [ADDR_W-1:0] word_address,
   input wire logic              select_n,
   input wire logic              gate_n,
   input wire logic              strobe_n,
   input wire logic [DATA_W-1:0] byte_bus_out,
   input wire logic              byte_bus_oe_n
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_strobe_width: assert property (
      $fell(strobe_n) |-> !select_n ##1 (!strobe_n && !select_n))
      else $error("write strobe too short");
   a_write_data: assert property (
      $past(!strobe_n) |-> $stable(byte_bus_out) && !byte_bus_oe_n)
      else $error("write data moved");
   a_select_addr: assert property (
      !select_n && $past(!select_n) |-> $stable(word_address))
      else $error("address moved while selected");
   a_no_contention: assert property (
      !byte_bus_oe_n |-> gate_n)
      else $error("bus driven with gate low");
   a_read_pins: assert property (
      !gate_n |-> strobe_n && !select_n)
      else $error("gate low outside a read");
   a_gate_width: assert property (
      $fell(gate_n) |-> !gate_n[*3])
      else $error("read window too short");
   a_retain_high: assert property (
      retain_ack |-> select_n)
      else $error("selected during retention");
   a_wake_wait: assert property (
      $fell(retain_ack) |-> select_n[*2])
      else $error("access too soon after retention");
   cover property ($rose(strobe_n));
   cover property ($rose(gate_n));
   cover property ($fell(retain_ack));
endmodule
bind asram_ctrl asram_ctrl_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
   u_asram_ctrl_asserts (.ref_clk(ref_clk), .resetn(resetn),
   .retain_ack(retain_ack), .word_address(word_address),
   .select_n(select_n), .gate_n(gate_n), .strobe_n(strobe_n),
   .byte_bus_out(byte_bus_out), .byte_bus_oe_n(byte_bus_oe_n));

// >>> verification/tb_top.sv
`timescale 1ns/100ps
module tb_top import asram_pkg::*;;
   logic [ASRAM_ADDR_W-1:0] req_addr, word_address;
   logic [7:0]  req_wdata, rsp_rdata, byte_bus_out;
   wire  [7:0]  bus;
   logic        ref_clk, resetn, req_valid, req_write, retain_req;
   logic        req_ready, rsp_valid, retain_ack, byte_bus_oe_n;
   logic        select_n, gate_n, strobe_n;
   int          errors, checks;
   logic [7:0]  exp_q[$];
   logic [7:0]  shadow [bit [ASRAM_ADDR_W-1:0]];
   asram_ctrl u_asram_ctrl (.ref_clk(ref_clk), .resetn(resetn),
      .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .retain_req(retain_req),
      .retain_ack(retain_ack), .word_address(word_address),
      .select_n(select_n), .gate_n(gate_n), .strobe_n(strobe_n),
      .byte_bus_in(bus), .byte_bus_out(byte_bus_out),
      .byte_bus_oe_n(byte_bus_oe_n));
   asram_mem_model u_asram_mem_model (.select_n(select_n),
      .gate_n(gate_n), .strobe_n(strobe_n), .word_address(word_address),
      .host_data(byte_bus_out), .host_oe_n(byte_bus_oe_n),
      .byte_bus(bus));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %0t read %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %0t pin %b want %b", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [ASRAM_ADDR_W-1:0] a,
                       input logic [7:0] d);
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr  <= a;
      req_wdata <= d;
      if (w) shadow[a] = d;
      else exp_q.push_back(shadow[a]);
      do @(posedge ref_clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge ref_clk)
      if (rsp_valid === 1'b1)
         chk_byte(rsp_rdata, exp_q.pop_front());
   initial begin
      logic [ASRAM_ADDR_W-1:0] a [8];
      errors = 0;
      checks = 0;
      {req_valid, req_write, retain_req, resetn} = 4'h0;
      req_addr = '0;
      req_wdata = 8'h00;
      void'($urandom(32'h19B5));
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      a[0] = '0;
      a[1] = '1;
      for (int i = 2; i < 8; i++) a[i] = ASRAM_ADDR_W'($urandom);
      foreach (a[i]) xfer(1'b1, a[i], 8'($urandom));
      xfer(1'b1, a[3], 8'h3C);
      xfer(1'b0, a[3], 8'h00);
      foreach (a[i]) xfer(1'b0, a[i], 8'h00);
      repeat (8) @(posedge ref_clk);
      $display("test 1 done");
      retain_req <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk_bit(retain_ack, 1'b1);
      chk_bit(select_n, 1'b1);
      chk_bit(req_ready, 1'b0);
      retain_req <= 1'b0;
      foreach (a[i]) xfer(1'b0, a[i], 8'h00);
      repeat (8) @(posedge ref_clk);
      // every read asked for must have come back
      chk_bit(exp_q.size() == 0, 1'b1);
      $display("test 2 done");
      print_verdict;
   end
   initial begin
      repeat (4000) @(posedge ref_clk);
      errors++;
      print_verdict;
   end
endmodule
